// File: gpb_regs.svh
// Register indices, field masks, reset values and pin map of the port block.
`ifndef GPB_REGS_SVH
`define GPB_REGS_SVH

// ===========================================================================
// Register indices (byte address is four times the index).
`define GPB_DATA_BASE   12'hFF0
`define GPB_DIR_BASE    12'hFF2
`define GPB_PU_BASE     12'hFF3
`define GPB_IN_PORT     4'h1
`define GPB_LAST_PORT   4'h6
`define GPB_ALIAS_BIT   21
`define GPB_BITNO_LSB   18

// ===========================================================================
// Reset values and reserved bit patterns.
`define GPB_DIR_RST     8'hFF
`define GPB_PU_RST      8'h00
`define GPB_LATCH_RST   8'h00
`define GPB_ALL_ONES    8'hFF
`define GPB_OWN_P6_WAIT 8'hF0
`define GPB_OWN_P6_FREE 8'hB0

// ===========================================================================
// Pin map of the 39-bit pad vectors, one slot per bidirectional port.
`define GPB_SLOTS       6
`define GPB_PADS        39
`define GPB_SLOT_P4     3
`define GPB_SLOT_P6     5
`define GPB_P0_LSB      0
`define GPB_P2_LSB      4
`define GPB_P3_LSB      11
`define GPB_P4_LSB      19
`define GPB_P5_LSB      27
`define GPB_P6_LSB      35
`define GPB_P5_IRQ_LSB  31
`define GPB_P6_OFS      4

`endif

// File: gpb_pkg.sv
// Types shared by the port block modules.
`default_nettype none
package gpb_pkg;
  typedef logic [7:0] gpb_byte_t;
  typedef logic [3:0] gpb_nib_t;
endpackage : gpb_pkg
`default_nettype wire

// File: gpb_port.sv
// One latched bidirectional port: latch, direction, pull-up and pad drive.
`timescale 1ns/1ps
`default_nettype none
`include "gpb_regs.svh"
module gpb_port #(
  parameter logic [7:0] IMPL = 8'hFF
) (
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  input  wire gpb_pkg::gpb_byte_t wdata_in,
  input  wire gpb_pkg::gpb_byte_t wmask_in,
  input  wire logic               wr_latch_in,
  input  wire logic               wr_dir_in,
  input  wire logic               wr_pu_in,
  input  wire gpb_pkg::gpb_byte_t pin_in,
  input  wire gpb_pkg::gpb_byte_t alt_out_in,
  input  wire gpb_pkg::gpb_byte_t alt_oe_in,
  input  wire gpb_pkg::gpb_byte_t own_in,
  output var  gpb_pkg::gpb_byte_t latch_out,
  output var  gpb_pkg::gpb_byte_t dir_out,
  output var  gpb_pkg::gpb_byte_t pu_out,
  output wire gpb_pkg::gpb_byte_t rd_out,
  output var  gpb_pkg::gpb_byte_t pad_out,
  output var  gpb_pkg::gpb_byte_t pad_oe_out,
  output var  gpb_pkg::gpb_byte_t pad_pu_out
);
  import gpb_pkg::*;

  // ========================================================================
  // Next values: only masked bits change, so bit and byte writes share logic.
  wire gpb_byte_t m       = wmask_in & IMPL;
  wire gpb_byte_t latch_d = wr_latch_in ?
                            ((latch_out & ~m) | (wdata_in & m)) : latch_out;
  wire gpb_byte_t dir_d   = (wr_dir_in ?
                            ((dir_out & ~m) | (wdata_in & m)) : dir_out)
                            | ~IMPL;
  wire gpb_byte_t pu_d    = (wr_pu_in ?
                            ((pu_out & ~m) | (wdata_in & m)) : pu_out)
                            & IMPL;

  // Readback mux: input-mode bits read the pin, output-mode bits read the latch.
  assign rd_out = ((dir_out & pin_in) | (~dir_out & latch_out)) & IMPL;

  // Pad drive: owner takes the pin, else direction or alternate output.
  wire gpb_byte_t oe_d  = (own_in & alt_oe_in) |
                          (~own_in & (~dir_out | alt_oe_in));
  // Alternate data is ORed on the latch, so a set latch masks it.
  wire gpb_byte_t out_d = (own_in & alt_out_in) |
                          (~own_in & (latch_out | (alt_out_in & alt_oe_in)));

  // Register state; input-mode writes only update the latch.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_out  <= `GPB_LATCH_RST;
      dir_out    <= `GPB_DIR_RST;
      pu_out     <= `GPB_PU_RST;
    end else begin
      latch_out  <= latch_d;
      dir_out    <= dir_d;
      pu_out     <= pu_d;
    end
  end

  // Registered pad controls; the enable is off while in reset.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pad_out    <= `GPB_LATCH_RST;
      pad_oe_out <= `GPB_PU_RST;
      pad_pu_out <= `GPB_PU_RST;
    end else begin
      pad_out    <= out_d & IMPL;
      pad_oe_out <= oe_d & IMPL;
      pad_pu_out <= pu_out;
    end
  end
endmodule : gpb_port
`default_nettype wire

// File: gpb_top.sv
// Port block top: APB register slave, six latched ports and input port.
`timescale 1ns/1ps
`default_nettype none
`include "gpb_regs.svh"
module gpb_top (
  input  wire logic                 clock_in,
  input  wire logic                 rstn_in,
  input  wire logic [21:0]          paddr_in,
  input  wire logic                 psel_in,
  input  wire logic                 penable_in,
  input  wire logic                 pwrite_in,
  input  wire logic [31:0]          pwdata_in,
  output logic      [31:0]          prdata_out,
  output logic                      pready_out,
  output logic                      pslverr_out,
  input  wire gpb_pkg::gpb_byte_t   analog_inputs_in,
  input  wire logic [`GPB_PADS-1:0] pad_in,
  output logic      [`GPB_PADS-1:0] pad_out,
  output logic      [`GPB_PADS-1:0] pad_oe_out,
  output logic      [`GPB_PADS-1:0] pad_pu_out,
  input  wire logic [`GPB_PADS-1:0] alt_out_in,
  input  wire logic [`GPB_PADS-1:0] alt_oe_in,
  input  wire logic                 exp_mode_in,
  input  wire logic                 wait_used_in,
  output logic      [7:0]           ext_irq_input_out
);
  import gpb_pkg::*;

  localparam int NS = `GPB_SLOTS;
  localparam int LSB [NS] = '{`GPB_P0_LSB, `GPB_P2_LSB, `GPB_P3_LSB,
                              `GPB_P4_LSB, `GPB_P5_LSB, `GPB_P6_LSB};
  localparam int WID [NS] = '{4, 7, 8, 8, 8, 4};
  localparam int OFS [NS] = '{0, 0, 0, 0, 0, `GPB_P6_OFS};

  // ========================================================================
  // Reset release through two flip-flops.
  logic rst_meta_n_q;
  logic rst_sync_n_q;

  // The whole design runs on the synchronised reset copy.
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_n_q <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end else begin
      rst_meta_n_q <= 1'b1;
      rst_sync_n_q <= rst_meta_n_q;
    end
  end

  // ========================================================================
  // Address decode: word index, bit alias flag and bit number.
  logic pready_q;
  wire [15:0]    idx      = paddr_in[17:2];
  wire gpb_nib_t pnum     = idx[3:0];
  wire           is_alias = paddr_in[`GPB_ALIAS_BIT];
  wire [2:0]     bitno    = paddr_in[`GPB_BITNO_LSB +: 3];
  wire           is_data  = idx[15:4] == `GPB_DATA_BASE;
  wire           is_dir   = idx[15:4] == `GPB_DIR_BASE;
  wire           is_pu    = idx[15:4] == `GPB_PU_BASE;
  wire           is_in    = is_data && (pnum == `GPB_IN_PORT);
  wire           pnum_ok  = pnum <= `GPB_LAST_PORT;
  wire [2:0]     slot     = (pnum == 4'h0) ? 3'h0 : 3'(pnum - 4'h1);
  wire           hit      = pnum_ok && (is_data ||
                            ((is_dir || is_pu) && !is_in &&
                             pnum != `GPB_IN_PORT));

  // Phases: setup prepares the answer, completion commits a write.
  wire setup = psel_in && !penable_in && !pready_q;
  wire done  = psel_in && penable_in && pready_q;
  wire wr_ok = done && pwrite_in && hit && !is_in;

  // Bit writes touch one bit of the addressed register only, byte writes every implemented bit.
  wire gpb_byte_t wmask = is_alias ? 8'(8'h01 << bitno)
                                   : `GPB_ALL_ONES;
  wire gpb_byte_t wdata = is_alias ? {8{pwdata_in[0]}}
                                   : pwdata_in[7:0];

  // ========================================================================
  // Port instances, one per bidirectional port.
  gpb_byte_t latch_w [NS];
  gpb_byte_t dir_w   [NS];
  gpb_byte_t pu_w    [NS];
  gpb_byte_t rd_w    [NS];
  gpb_byte_t pout_w  [NS];
  gpb_byte_t poe_w   [NS];
  gpb_byte_t ppu_w   [NS];

  for (genvar k = 0; k < NS; k++) begin : g_port
    localparam logic [7:0] IMPL =
      8'((9'h001 << WID[k]) - 9'h001) << OFS[k];
    wire gpb_byte_t pin  = 8'(pad_in[LSB[k] +: WID[k]]) << OFS[k];
    wire gpb_byte_t aout = 8'(alt_out_in[LSB[k] +: WID[k]]) << OFS[k];
    wire gpb_byte_t aoe  = 8'(alt_oe_in[LSB[k] +: WID[k]]) << OFS[k];
    // Expansion mode hands the bus pins to the external bus logic.
    wire gpb_byte_t own  =
      !exp_mode_in ? 8'h00 :
      (k == `GPB_SLOT_P4) ? `GPB_ALL_ONES :
      (k == `GPB_SLOT_P6) ? (wait_used_in ? `GPB_OWN_P6_WAIT
                                          : `GPB_OWN_P6_FREE) :
      8'h00;
    wire sel = (3'(k) == slot);

    gpb_port #(.IMPL(IMPL)) u_port (
      .clk_in      (clock_in),
      .rst_n_in    (rst_sync_n_q),
      .wdata_in    (wdata),
      .wmask_in    (wmask),
      .wr_latch_in (wr_ok && sel && is_data),
      .wr_dir_in   (wr_ok && sel && is_dir),
      .wr_pu_in    (wr_ok && sel && is_pu),
      .pin_in      (pin),
      .alt_out_in  (aout),
      .alt_oe_in   (aoe),
      .own_in      (own),
      .latch_out   (latch_w[k]),
      .dir_out     (dir_w[k]),
      .pu_out      (pu_w[k]),
      .rd_out      (rd_w[k]),
      .pad_out     (pout_w[k]),
      .pad_oe_out  (poe_w[k]),
      .pad_pu_out  (ppu_w[k])
    );

    // Pad vectors are taken straight from the port's flip-flops.
    assign pad_out[LSB[k] +: WID[k]]    = pout_w[k][OFS[k] +: WID[k]];
    assign pad_oe_out[LSB[k] +: WID[k]] = poe_w[k][OFS[k] +: WID[k]];
    assign pad_pu_out[LSB[k] +: WID[k]] = ppu_w[k][OFS[k] +: WID[k]];
  end

  // ========================================================================
  // Read data selection.
  wire [2:0] rslot = (slot < 3'(NS)) ? slot : 3'h0;
  wire gpb_byte_t rd_byte =
    is_in   ? analog_inputs_in :
    is_data ? rd_w[rslot] :
    is_dir  ? dir_w[rslot] : pu_w[rslot];
  wire [31:0] rd_word = !hit     ? 32'h0000_0000 :
                        is_alias ? {31'h0000_0000, rd_byte[bitno]}
                                 : {24'h00_0000, rd_byte};

  logic [31:0] prdata_q;
  logic        pslverr_q;

  // One wait-free answer: pready rises in the first access cycle.
  always_ff @(posedge clock_in or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup ? !hit : pslverr_q;
      prdata_q  <= (setup && !pwrite_in) ? rd_word : prdata_q;
    end
  end

  assign pready_out  = pready_q;
  assign pslverr_out = pslverr_q;
  assign prdata_out  = prdata_q;

  // ========================================================================
  // Interrupt pin levels, including levels the block drives itself.
  wire [`GPB_PADS-1:0] lvl = (pad_oe_out & pad_out) |
                             (~pad_oe_out & pad_in);
  logic [7:0] irq_q;

  // Port 0 and upper port 5 feed the interrupt and trigger inputs.
  always_ff @(posedge clock_in or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      irq_q <= 8'h00;
    end else begin
      irq_q <= {lvl[`GPB_P5_IRQ_LSB +: 4], lvl[`GPB_P0_LSB +: 4]};
    end
  end

  assign ext_irq_input_out = irq_q;

  // ========================================================================
  // Checks on the block's own behaviour.
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_sync_n_q);

  // Helpers holding the previous cycle's slot, bit and data, and whether that cycle committed a bit write to an implemented data register bit.
  logic [2:0] chk_slot_q;
  logic [2:0] chk_bit_q;
  logic       chk_val_q;
  logic       chk_bw_q;

  // Captures the target of a bit write to a data register.
  always_ff @(posedge clock_in or negedge rst_sync_n_q) begin
    if (!rst_sync_n_q) begin
      chk_slot_q <= 3'h0;
      chk_bit_q  <= 3'h0;
      chk_val_q  <= 1'b0;
      chk_bw_q   <= 1'b0;
    end else begin
      chk_slot_q <= rslot;
      chk_bit_q  <= bitno;
      chk_val_q  <= pwdata_in[0];
      chk_bw_q   <= wr_ok && is_data && is_alias &&
                    (WID[rslot] + OFS[rslot] > int'(bitno)) &&
                    (OFS[rslot] <= int'(bitno));
    end
  end

  a_answer_next: assert property (setup |=> pready_out &&
    pslverr_out == !$past(hit))
    else $error("pready did not follow setup");
  a_answer_once: assert property (pready_out |=> !pready_out)
    else $error("pready held for two cycles");
  a_unmapped_err: assert property (setup && !hit |=> pslverr_out)
    else $error("unmapped access without error");
  a_reset_inputs: assert property ($rose(rst_sync_n_q) |->
    pad_oe_out == '0)
    else $error("pad driven right after reset");
  a_bit_write: assert property (chk_bw_q |->
    latch_w[chk_slot_q][chk_bit_q] == chk_val_q)
    else $error("bit write did not reach latch");
  a_dir_out_mode: assert property (wr_ok && is_dir && !is_alias &&
    slot == 3'h2 && pwdata_in[7:0] == 8'h00 && !exp_mode_in |=> ##1
    pad_oe_out[`GPB_P3_LSB +: 8] == 8'hFF)
    else $error("direction zero did not enable driver");
  a_pullup_follow: assert property (wr_ok && is_pu && !is_alias &&
    slot == 3'h0 |=> ##1 pad_pu_out[3:0] == $past(pwdata_in[3:0], 2))
    else $error("pull-up did not follow register");
  a_input_read: assert property (setup && !pwrite_in && is_in &&
    !is_alias |=> prdata_out[7:0] == $past(analog_inputs_in))
    else $error("input port read mismatch");
  a_input_undriven: assert property (dir_w[0][0] && !alt_oe_in[0]
    |=> !pad_oe_out[0])
    else $error("input-mode pin driven");
  a_bus_owns: assert property (exp_mode_in |=>
    pad_oe_out[`GPB_P4_LSB +: 8] == $past(alt_oe_in[`GPB_P4_LSB +: 8]))
    else $error("bus pins not owned in expansion mode");
  a_wait_free: assert property (exp_mode_in && !wait_used_in |=>
    pad_oe_out[37] == $past(!dir_w[`GPB_SLOT_P6][6] || alt_oe_in[37]))
    else $error("wait pin not usable as port pin");
  // The level flop still resets on the release edge, so wait for it.
  a_irq_level: assert property (rst_sync_n_q |=>
    ext_irq_input_out[3:0] == $past(lvl[3:0]))
    else $error("interrupt level not passed on");

  c_byte_write: cover property (wr_ok && !is_alias && is_data);
  c_bit_write:  cover property (wr_ok && is_alias);
  c_read_in:    cover property (done && !pwrite_in && is_in);
  c_err:        cover property (done && pslverr_out);
  c_exp_mode:   cover property (exp_mode_in && wait_used_in);
endmodule : gpb_top
`default_nettype wire

// File: gpb_board.sv
// Board-side model of the port pins: external drivers, pull-ups, floating lines.
`timescale 1ns/1ps
`default_nettype none
`include "gpb_regs.svh"
module gpb_board (
  input  wire logic                 clock_in,
  input  wire logic [`GPB_PADS-1:0] pad_out_in,
  input  wire logic [`GPB_PADS-1:0] pad_oe_in,
  input  wire logic [`GPB_PADS-1:0] pad_pu_in,
  input  wire logic [`GPB_PADS-1:0] ext_en_in,
  input  wire logic [`GPB_PADS-1:0] ext_lvl_in,
  output logic      [`GPB_PADS-1:0] lvl_out
);
  logic float_q = 1'b0;

  // An undriven line without pull-up wanders, so it toggles every cycle.
  always_ff @(posedge clock_in) begin
    float_q <= ~float_q;
  end

  // Block drive wins, then the board driver, then the pull-up.
  always_comb begin
    for (int i = 0; i < `GPB_PADS; i++) begin
      lvl_out[i] = pad_oe_in[i] ? pad_out_in[i] :
                   ext_en_in[i] ? ext_lvl_in[i] :
                   pad_pu_in[i] ? 1'b1 : float_q;
    end
  end
endmodule : gpb_board
`default_nettype wire

// File: tb_top.sv
// Self-checking bench of the port block over its APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "gpb_regs.svh"
module tb_top;
  import gpb_pkg::*;
  // ==========================================================================
  // Port table: register number, implemented bits, pad base.
  localparam logic [3:0] PN [6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
  localparam logic [7:0] PM [6] = '{8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'hFF,
                                    8'hF0};
  localparam int PB [6] = '{`GPB_P0_LSB, `GPB_P2_LSB, `GPB_P3_LSB,
    `GPB_P4_LSB, `GPB_P5_LSB, `GPB_P6_LSB - `GPB_P6_OFS};
  logic                 clock_in;
  logic                 rstn_in;
  logic [21:0]          paddr;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  gpb_byte_t            analog;
  logic [`GPB_PADS-1:0] pad_in;
  logic [`GPB_PADS-1:0] pad_out;
  logic [`GPB_PADS-1:0] pad_oe;
  logic [`GPB_PADS-1:0] pad_pu;
  logic [`GPB_PADS-1:0] alt_out;
  logic [`GPB_PADS-1:0] alt_oe;
  logic [`GPB_PADS-1:0] ext_en;
  logic [`GPB_PADS-1:0] ext_lvl;
  logic                 exp_mode;
  logic                 wait_used;
  logic [7:0]           irq;
  logic [31:0]          rdv;
  logic                 errv;
  int                   n_fail = 0;
  int                   checked = 0;

  gpb_top dut (.clock_in(clock_in), .rstn_in(rstn_in), .paddr_in(paddr),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .analog_inputs_in(analog), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_out(pad_oe), .pad_pu_out(pad_pu),
    .alt_out_in(alt_out), .alt_oe_in(alt_oe), .exp_mode_in(exp_mode),
    .wait_used_in(wait_used), .ext_irq_input_out(irq));
  gpb_board board (.clock_in(clock_in), .pad_out_in(pad_out),
    .pad_oe_in(pad_oe), .pad_pu_in(pad_pu), .ext_en_in(ext_en),
    .ext_lvl_in(ext_lvl), .lvl_out(pad_in));

  // ==========================================================================
  // Helpers.
  function automatic logic [7:0] pb(input logic [`GPB_PADS-1:0] v,
                                    input int k);
    pb = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (PM[k][i]) pb[i] = v[PB[k] + i];
    end
  endfunction : pb

  function automatic logic [15:0] ix(input logic [11:0] b, input int k);
    ix = {b, PN[k]};
  endfunction : ix

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; bs[3] selects the bit alias, bs[2:0] the bit.
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [3:0] bs, input logic [7:0] wd);
    @(posedge clock_in);
    paddr <= {bs, idx, 2'b00};
    pwrite <= wr;
    pwdata <= {24'h0, wd};
    psel <= 1'b1;
    @(posedge clock_in);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge clock_in);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, 4'h0, d);
  endtask : wr

  task automatic rc(input string nm, input logic [15:0] idx,
                    input logic [3:0] bs, input logic [7:0] e);
    apb(1'b0, idx, bs, 8'h00);
    chk(nm, {24'h0, e}, rdv);
  endtask : rc

  task automatic settle();
    repeat (4) @(posedge clock_in);
  endtask : settle

  task automatic tally_and_finish();
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // Clock, watchdog and test sequence.
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  initial begin
    #5000000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    rstn_in = 1'b0;
    {paddr, psel, penable, pwrite, pwdata} = '0;
    {alt_out, alt_oe, exp_mode, wait_used} = '0;
    analog = 8'h96;
    ext_en = '1;
    ext_lvl = 39'h2A_C3A5_3C96;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    // Each port: reset values, input-mode writes, then output mode.
    for (int k = 0; k < 6; k++) begin
      rc("dir_rst", ix(`GPB_DIR_BASE, k), 4'h0, 8'hFF);
      rc("pu_rst", ix(`GPB_PU_BASE, k), 4'h0, 8'h00);
      chk("oe_rst", 32'h0, pb(pad_oe, k));
      wr(ix(`GPB_DATA_BASE, k), 8'h5A);
      settle();
      chk("oe_in", 32'h0, pb(pad_oe, k));
      rc("pin_rd", ix(`GPB_DATA_BASE, k), 4'h0, pb(ext_lvl, k));
      wr(ix(`GPB_PU_BASE, k), 8'hFF);
      rc("pu_rd", ix(`GPB_PU_BASE, k), 4'h0, PM[k]);
      wr(ix(`GPB_DIR_BASE, k), 8'h00);
      rc("dir_rd", ix(`GPB_DIR_BASE, k), 4'h0, ~PM[k]);
      settle();
      chk("oe_out", PM[k], pb(pad_oe, k));
      chk("pad_val", 8'h5A & PM[k], pb(pad_out, k));
      chk("pu_pad", PM[k], pb(pad_pu, k));
      rc("latch_rd", ix(`GPB_DATA_BASE, k), 4'h0, 8'h5A & PM[k]);
      if (k == 0) chk("irq_p0", 32'hA, irq[3:0]);
      if (k == 4) chk("irq_p5", 32'h5, irq[7:4]);
      wr(ix(`GPB_DIR_BASE, k), 8'hFF);
      wr(ix(`GPB_PU_BASE, k), 8'h00);
    end
    // Input-only port and refused addresses.
    rc("in_port", {`GPB_DATA_BASE, 4'h1}, 4'h0, 8'h96);
    wr({`GPB_DATA_BASE, 4'h1}, 8'h00);
    chk("in_wr_err", 32'h0, errv);
    rc("in_dir", {`GPB_DIR_BASE, 4'h1}, 4'h0, 8'h00);
    chk("in_dir_err", 32'h1, errv);
    // Single-bit accesses through the alias.
    apb(1'b1, ix(`GPB_DIR_BASE, 2), 4'hA, 8'h00);
    rc("bit_dir", ix(`GPB_DIR_BASE, 2), 4'h0, 8'hFB);
    rc("bit_rd2", ix(`GPB_DIR_BASE, 2), 4'hA, 8'h00);
    rc("bit_rd3", ix(`GPB_DIR_BASE, 2), 4'hB, 8'h01);
    settle();
    chk("bit_oe", 32'h04, pb(pad_oe, 2));
    apb(1'b1, ix(`GPB_DATA_BASE, 2), 4'hA, 8'h01);
    rc("bit_latch", ix(`GPB_DATA_BASE, 2), 4'hA, 8'h01);
    settle();
    chk("bit_keep", 32'h5E, pb(pad_out, 2));
    apb(1'b1, ix(`GPB_DATA_BASE, 0), 4'hF, 8'h01);
    rc("bit_unimpl", ix(`GPB_DATA_BASE, 0), 4'hF, 8'h00);
    // Transmit pin: output mode, latch 0, alternate drive.
    wr(ix(`GPB_DATA_BASE, 1), 8'h00);
    wr(ix(`GPB_DIR_BASE, 1), 8'hFD);
    rc("rx_pin", ix(`GPB_DATA_BASE, 1), 4'h8, {7'h00, ext_lvl[4]});
    alt_oe <= 39'h30;
    alt_out <= 39'h20;
    settle();
    chk("alt_hi", 32'h1, pad_out[5]);
    chk("alt_oe_in", 32'h1, pad_oe[4]);
    alt_out <= 39'h00;
    settle();
    chk("alt_lo", 32'h0, pad_out[5]);
    // Expansion mode ownership of ports 4 and 6.
    wr(ix(`GPB_DIR_BASE, 3), 8'h00);
    wr(ix(`GPB_DIR_BASE, 5), 8'h00);
    alt_oe <= {4'b1011, 8'h00, 8'h0F, 19'h0};
    alt_out <= {4'h0, 8'h00, 8'hC3, 19'h0};
    settle();
    chk("p4_own_off", 32'hFF, pb(pad_oe, 3));
    exp_mode <= 1'b1;
    settle();
    chk("p4_own_oe", 32'h0F, pb(pad_oe, 3));
    chk("p4_own_out", 32'hC3, pb(pad_out, 3));
    chk("p6_free", 32'hF0, pb(pad_oe, 5));
    wait_used <= 1'b1;
    settle();
    chk("p6_wait", 32'hB0, pb(pad_oe, 5));
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
